// >>> src/dbcs_bank.sv
`include "dbcs_defines.svh"
`default_nettype none
module dbcs_bank
	import dbcs_pkg::*;
#(
	parameter int RCD_CYC = `DBCS_RCD_CYC,
	parameter int RP_CYC  = `DBCS_RP_CYC,
	parameter int WR_CYC  = `DBCS_WR_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       en_i,
	input  wire logic       act_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic       ap_i,
	input  wire logic       pre_i,
	input  wire logic       intr_i,
	input  wire logic       live_i,
	output logic            idle_o,
	output dbcs_bank_state_t state_o
);
	localparam int CNT_W = `DBCS_CNT_W;

	if (RCD_CYC < 1 || RP_CYC < 1 || WR_CYC < 1 || RCD_CYC > 255 || RP_CYC > 255 || WR_CYC > 255)
	begin : g_bad_cfg
		$error("dbcs_bank: timing counts must lie in 1..255");
	end

	dbcs_bank_state_t state_ff;
	dbcs_bank_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	assign state_o = state_ff;
	assign idle_o  = (state_ff == DBCS_BANK_IDLE);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = (cnt_ff != '0) ? cnt_ff - 1'b1 : '0;
		case (state_ff)
			// [R21] Idle accepts activate
			DBCS_BANK_IDLE: begin
				if (act_i) begin
					nxt_state = DBCS_BANK_ACTIVATING;
					nxt_cnt   = CNT_W'(RCD_CYC - 1);
				end
			end
			// [R24] Activate-to-column counter
			DBCS_BANK_ACTIVATING: begin
				if (cnt_ff == '0) begin
					nxt_state = DBCS_BANK_ACTIVE;
				end
			end
			// [R18] Row active and bursts
			DBCS_BANK_ACTIVE, DBCS_BANK_READ, DBCS_BANK_WRITE: begin
				if (rd_i) begin
					nxt_state = ap_i ? DBCS_BANK_READ_AP : DBCS_BANK_READ;
				end else if (wr_i) begin
					nxt_state = ap_i ? DBCS_BANK_WRITE_AP : DBCS_BANK_WRITE;
				end else if (pre_i) begin
					// [R19] Precharge truncates burst
					nxt_state = DBCS_BANK_PRECHARGING;
					nxt_cnt   = CNT_W'(RP_CYC - 1);
				end else if (state_ff != DBCS_BANK_ACTIVE && !live_i) begin
					// [R21] Burst over, row active
					nxt_state = DBCS_BANK_ACTIVE;
				end
			end
			// [R2] Precharge on interrupting edge
			DBCS_BANK_READ_AP: begin
				if (intr_i || !live_i) begin
					nxt_state = DBCS_BANK_PRECHARGING;
					nxt_cnt   = CNT_W'(RP_CYC - 1);
				end
			end
			// [R5] Write gap from interrupt
			DBCS_BANK_WRITE_AP: begin
				if (intr_i || !live_i) begin
					nxt_state = DBCS_BANK_WR_GAP;
					nxt_cnt   = CNT_W'(WR_CYC - 1);
				end
			end
			// [R7] Precharge after write gap
			DBCS_BANK_WR_GAP: begin
				if (cnt_ff == '0) begin
					nxt_state = DBCS_BANK_PRECHARGING;
					nxt_cnt   = CNT_W'(RP_CYC - 1);
				end
			end
			DBCS_BANK_PRECHARGING: begin
				if (cnt_ff == '0) begin
					nxt_state = DBCS_BANK_IDLE;
				end
			end
			default: begin
				nxt_state = DBCS_BANK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_ff <= DBCS_BANK_IDLE;
			cnt_ff   <= '0;
		end else if (en_i) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end
endmodule // dbcs_bank
`default_nettype wire

// >>> src/dbcs_core.sv
`include "dbcs_defines.svh"
`default_nettype none
module dbcs_core
	import dbcs_pkg::*;
#(
	parameter int READ_LATENCY = `DBCS_READ_LATENCY,
	parameter int BURST_LEN    = `DBCS_BURST_LEN,
	parameter int RCD_CYC      = `DBCS_RCD_CYC,
	parameter int RP_CYC       = `DBCS_RP_CYC,
	parameter int WR_CYC       = `DBCS_WR_CYC,
	parameter int XSR_CYC      = `DBCS_XSR_CYC,
	parameter int FIFO_DEPTH   = `DBCS_FIFO_DEPTH,
	parameter int DATA_W       = `DBCS_DATA_W
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	input  wire logic                       clock_enable_input_i,
	input  wire logic                       chip_select_n_i,
	input  wire logic                       row_strobe_n_i,
	input  wire logic                       column_strobe_n_i,
	input  wire logic                       write_strobe_n_i,
	input  wire logic [`DBCS_BANK_W-1:0]    bank_i,
	input  wire logic [`DBCS_ADDR_W-1:0]    addr_i,
	input  wire logic                       data_mask_i,
	input  wire logic [DATA_W-1:0]          write_data_i,
	output logic      [DATA_W-1:0]          read_data_o,
	output logic                            read_data_oe_o,
	output logic                            write_ready_o,
	output logic                            arr_act_valid_o,
	output logic      [`DBCS_BANK_W-1:0]    arr_act_bank_o,
	output logic      [`DBCS_ADDR_W-1:0]    arr_act_row_o,
	output logic                            arr_rd_valid_o,
	output logic      [`DBCS_BANK_W-1:0]    arr_rd_bank_o,
	output logic      [`DBCS_COL_W-1:0]     arr_rd_col_o,
	input  wire logic [DATA_W-1:0]          arr_rd_data_i,
	output logic                            arr_wr_valid_o,
	input  wire logic                       arr_wr_ready_i,
	output logic      [`DBCS_BANK_W-1:0]    arr_wr_bank_o,
	output logic      [`DBCS_COL_W-1:0]     arr_wr_col_o,
	output logic      [DATA_W-1:0]          arr_wr_data_o,
	output dbcs_pwr_t                       power_mode_o,
	output logic      [`DBCS_NUM_BANKS-1:0] bank_idle_o
);
	localparam int BANK_W = `DBCS_BANK_W;
	localparam int COL_W  = `DBCS_COL_W;
	localparam int NB     = `DBCS_NUM_BANKS;
	localparam int CNT_W  = `DBCS_CNT_W;
	localparam int BL_W   = $clog2(BURST_LEN + 1);
	localparam int RA_W   = BANK_W + COL_W;
	localparam int WORD_W = RA_W + DATA_W;
	localparam int MLAT   = `DBCS_MASK_RD_LAT;

	if (READ_LATENCY < 1 || BURST_LEN < 1 || XSR_CYC < 1 || XSR_CYC > 255) begin : g_bad_cfg
		$error("dbcs_core: latency, burst length or exit delay out of range");
	end

	// [R17] Strobe pattern decode
	function automatic dbcs_cmd_t decode_cmd(input logic cs_n, input logic [2:0] strobes);
		dbcs_cmd_t c;
		c = DBCS_CMD_NOP;
		if (cs_n) begin
			c = DBCS_CMD_INHIBIT;
		end else begin
			case (strobes)
				3'h7: c = DBCS_CMD_NOP;
				3'h3: c = DBCS_CMD_ACTIVE;
				3'h1: c = DBCS_CMD_REFRESH;
				3'h0: c = DBCS_CMD_LOAD_MODE;
				3'h2: c = DBCS_CMD_PRECHARGE;
				3'h5: c = DBCS_CMD_READ;
				3'h4: c = DBCS_CMD_WRITE;
				3'h6: c = DBCS_CMD_BURST_STOP;
				default: c = DBCS_CMD_NOP;
			endcase
		end
		return c;
	endfunction

	dbcs_cmd_t        cmd;
	dbcs_pwr_t        pwr_ff;
	dbcs_pwr_t        nxt_pwr;
	logic [CNT_W-1:0] xsr_ff;
	logic [CNT_W-1:0] nxt_xsr;
	logic             cke_prev_ff;
	logic             cke_fall;
	logic             cke_rise;
	logic             is_nop;
	logic             run;
	logic             all_idle;
	logic             busy;

	logic [BL_W-1:0]   rd_left_ff;
	logic [BANK_W-1:0] rd_bank_ff;
	logic [COL_W-1:0]  rd_col_ff;
	logic [BL_W-1:0]   wr_left_ff;
	logic [BANK_W-1:0] wr_bank_ff;
	logic [COL_W-1:0]  wr_col_ff;
	logic              rd_pipe_v_ff [READ_LATENCY];
	logic [RA_W-1:0]   rd_pipe_a_ff [READ_LATENCY];
	logic              mask_pipe_ff [MLAT];
	logic              rd_pipe_any;

	logic [NB-1:0]    col_ok;
	logic [NB-1:0]    live;
	dbcs_bank_state_t bank_state [NB];

	logic             rd_cmd;
	logic             wr_cmd;
	logic             act_cmd;
	logic             pre_cmd;
	logic             stop_cmd;
	logic             ap;
	logic             pre_hits_rd;
	logic             pre_hits_wr;
	logic             rd_issue;
	logic [RA_W-1:0]  rd_issue_a;
	logic             wr_beat;
	logic [RA_W-1:0]  wr_beat_a;
	logic             fifo_in_valid;
	logic [WORD_W-1:0] fifo_out;

	assign cmd      = decode_cmd(chip_select_n_i, {row_strobe_n_i, column_strobe_n_i, write_strobe_n_i});
	// [R16] Inhibit and NOP change nothing
	assign is_nop   = (cmd == DBCS_CMD_INHIBIT) || (cmd == DBCS_CMD_NOP);
	assign cke_fall = cke_prev_ff && !clock_enable_input_i;
	assign cke_rise = !cke_prev_ff && clock_enable_input_i;
	// [R15] Decode only with enable high twice
	assign run      = (pwr_ff == DBCS_PWR_NORMAL) && cke_prev_ff && clock_enable_input_i;
	assign all_idle = &bank_idle_o;

	always_comb begin
		rd_pipe_any = 1'b0;
		for (int i = 0; i < READ_LATENCY; i++) begin
			rd_pipe_any = rd_pipe_any | rd_pipe_v_ff[i];
		end
	end
	assign busy = (rd_left_ff != '0) || (wr_left_ff != '0) || rd_pipe_any || read_data_oe_o;

	assign ap       = addr_i[`DBCS_AP_BIT];
	assign act_cmd  = run && (cmd == DBCS_CMD_ACTIVE) && bank_idle_o[bank_i];
	// [R18] Column access only on open row
	assign rd_cmd   = run && (cmd == DBCS_CMD_READ) && col_ok[bank_i];
	assign wr_cmd   = run && (cmd == DBCS_CMD_WRITE) && col_ok[bank_i];
	assign pre_cmd  = run && (cmd == DBCS_CMD_PRECHARGE);
	assign stop_cmd = run && (cmd == DBCS_CMD_BURST_STOP);
	assign pre_hits_rd = pre_cmd && (ap || bank_i == rd_bank_ff);
	assign pre_hits_wr = pre_cmd && (ap || bank_i == wr_bank_ff);

	// Power and clock-enable state
	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_xsr = (xsr_ff != '0) ? xsr_ff - 1'b1 : '0;
		case (pwr_ff)
			// [R8] Fall action from prior state
			DBCS_PWR_NORMAL: begin
				if (cke_fall) begin
					if (all_idle && !busy) begin
						if (is_nop) begin
							nxt_pwr = DBCS_PWR_DOWN;
						end else if (cmd == DBCS_CMD_REFRESH) begin
							nxt_pwr = DBCS_PWR_SELF_REFRESH;
						end else if (cmd == DBCS_CMD_BURST_STOP) begin
							// [R13] Deep power-down entry
							nxt_pwr = DBCS_PWR_DEEP_DOWN;
						end
					end else if (busy) begin
						nxt_pwr = DBCS_PWR_SUSPEND;
					end else if (is_nop) begin
						nxt_pwr = DBCS_PWR_DOWN;
					end
				end
			end
			// [R10] Exit with NOP on rise
			DBCS_PWR_DOWN: begin
				if (cke_rise && is_nop) begin
					nxt_pwr = DBCS_PWR_NORMAL;
				end
			end
			DBCS_PWR_SELF_REFRESH: begin
				if (cke_rise && is_nop) begin
					nxt_pwr = DBCS_PWR_SR_EXIT;
					nxt_xsr = CNT_W'(XSR_CYC - 1);
				end
			end
			// [R11] Wait out self-refresh exit delay
			DBCS_PWR_SR_EXIT: begin
				if (xsr_ff == '0) begin
					nxt_pwr = DBCS_PWR_NORMAL;
				end
			end
			// [R12] Resume on edge after exit
			DBCS_PWR_SUSPEND: begin
				if (cke_rise) begin
					nxt_pwr = DBCS_PWR_NORMAL;
				end
			end
			// [R13] Any rise leaves deep power-down
			DBCS_PWR_DEEP_DOWN: begin
				if (cke_rise) begin
					nxt_pwr = DBCS_PWR_NORMAL;
				end
			end
			default: begin
				nxt_pwr = DBCS_PWR_NORMAL;
			end
		endcase
	end

	// [R9] Enable sampled every edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cke_prev_ff <= 1'b0;
			pwr_ff      <= DBCS_PWR_NORMAL;
			xsr_ff      <= '0;
		end else begin
			cke_prev_ff <= clock_enable_input_i;
			pwr_ff      <= nxt_pwr;
			xsr_ff      <= nxt_xsr;
		end
	end
	assign power_mode_o = pwr_ff;

	// Per-bank state trackers
	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic hit;
		assign hit = (bank_i == BANK_W'(b));
		assign col_ok[b] = (bank_state[b] == DBCS_BANK_ACTIVE) || (bank_state[b] == DBCS_BANK_READ)
			|| (bank_state[b] == DBCS_BANK_WRITE);
		assign live[b] = ((rd_left_ff != '0) && rd_bank_ff == BANK_W'(b))
			|| ((wr_left_ff != '0) && wr_bank_ff == BANK_W'(b));
		dbcs_bank #(
			.RCD_CYC (RCD_CYC),
			.RP_CYC  (RP_CYC),
			.WR_CYC  (WR_CYC)
		) u_bank (
			.clk_i   (clk_i),
			.reset_i (reset_i),
			.en_i    (run),
			.act_i   (act_cmd && hit),
			.rd_i    (rd_cmd && hit),
			.wr_i    (wr_cmd && hit),
			.ap_i    (ap),
			.pre_i   (pre_cmd && (ap || hit)),
			.intr_i  ((rd_cmd || wr_cmd) && !hit),
			.live_i  (live[b]),
			.idle_o  (bank_idle_o[b]),
			.state_o (bank_state[b])
		);
	end

	// Row open request to the array
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			arr_act_valid_o <= 1'b0;
			arr_act_bank_o  <= '0;
			arr_act_row_o   <= '0;
		end else begin
			arr_act_valid_o <= act_cmd;
			if (act_cmd) begin
				arr_act_bank_o <= bank_i;
				arr_act_row_o  <= addr_i;
			end
		end
	end

	// [R19] Read burst column issue
	assign rd_issue   = rd_cmd || ((rd_left_ff != '0) && !wr_cmd && !stop_cmd && !pre_hits_rd);
	assign rd_issue_a = rd_cmd ? {bank_i, addr_i[COL_W-1:0]} : {rd_bank_ff, rd_col_ff};

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_left_ff <= '0;
			rd_bank_ff <= '0;
			rd_col_ff  <= '0;
		end else if (run) begin
			if (rd_cmd) begin
				rd_left_ff <= BL_W'(BURST_LEN - 1);
				rd_bank_ff <= bank_i;
				rd_col_ff  <= addr_i[COL_W-1:0] + 1'b1;
			end else if (wr_cmd || stop_cmd || pre_hits_rd) begin
				// [R3] Write ends read burst
				rd_left_ff <= '0;
			end else if (rd_left_ff != '0) begin
				rd_left_ff <= rd_left_ff - 1'b1;
				rd_col_ff  <= rd_col_ff + 1'b1;
			end
		end
	end

	// [R1] Latency pipeline for read data
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < READ_LATENCY; i++) begin
				rd_pipe_v_ff[i] <= 1'b0;
				rd_pipe_a_ff[i] <= '0;
			end
		end else if (run) begin
			// [R3] Flush read data on write
			rd_pipe_v_ff[0] <= rd_issue && !wr_cmd;
			rd_pipe_a_ff[0] <= rd_issue_a;
			for (int i = 1; i < READ_LATENCY; i++) begin
				rd_pipe_v_ff[i] <= rd_pipe_v_ff[i-1] && !wr_cmd;
				rd_pipe_a_ff[i] <= rd_pipe_a_ff[i-1];
			end
		end
	end

	assign arr_rd_valid_o = rd_pipe_v_ff[READ_LATENCY-1] && run;
	assign arr_rd_bank_o  = rd_pipe_a_ff[READ_LATENCY-1][RA_W-1:COL_W];
	assign arr_rd_col_o   = rd_pipe_a_ff[READ_LATENCY-1][COL_W-1:0];

	// Read mask acts two edges late
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < MLAT; i++) begin
				mask_pipe_ff[i] <= 1'b0;
			end
		end else if (run) begin
			mask_pipe_ff[0] <= data_mask_i;
			for (int i = 1; i < MLAT; i++) begin
				mask_pipe_ff[i] <= mask_pipe_ff[i-1];
			end
		end
	end

	// Output held while clock is suspended
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			read_data_o    <= '0;
			read_data_oe_o <= 1'b0;
		end else if (run) begin
			read_data_oe_o <= rd_pipe_v_ff[READ_LATENCY-1] && !mask_pipe_ff[MLAT-1] && !wr_cmd;
			if (rd_pipe_v_ff[READ_LATENCY-1]) begin
				read_data_o <= arr_rd_data_i;
			end
		end
	end

	// [R20] Write burst beats
	assign wr_beat   = wr_cmd || ((wr_left_ff != '0) && !rd_cmd && !stop_cmd && !pre_hits_wr);
	assign wr_beat_a = wr_cmd ? {bank_i, addr_i[COL_W-1:0]} : {wr_bank_ff, wr_col_ff};
	// [R6] Interrupting read stores nothing
	assign fifo_in_valid = run && wr_beat && !data_mask_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_left_ff <= '0;
			wr_bank_ff <= '0;
			wr_col_ff  <= '0;
		end else if (run) begin
			if (wr_cmd) begin
				wr_left_ff <= BL_W'(BURST_LEN - 1);
				wr_bank_ff <= bank_i;
				wr_col_ff  <= addr_i[COL_W-1:0] + 1'b1;
			end else if (rd_cmd || stop_cmd || pre_hits_wr) begin
				// [R5] Read ends write burst
				wr_left_ff <= '0;
			end else if (wr_left_ff != '0) begin
				wr_left_ff <= wr_left_ff - 1'b1;
				wr_col_ff  <= wr_col_ff + 1'b1;
			end
		end
	end

	// [R7] New write's own word only
	dbcs_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (write_ready_o),
		.in_data_i   ({wr_beat_a, write_data_i}),
		.out_valid_o (arr_wr_valid_o),
		.out_ready_i (arr_wr_ready_i),
		.out_data_o  (fifo_out)
	);

	assign arr_wr_bank_o = fifo_out[WORD_W-1:WORD_W-BANK_W];
	assign arr_wr_col_o  = fifo_out[DATA_W+COL_W-1:DATA_W];
	assign arr_wr_data_o = fifo_out[DATA_W-1:0];
endmodule // dbcs_core
`default_nettype wire

// >>> src/dbcs_defines.svh
// Functional notes
// [R1] Interrupting read's data replaces old after latency
// [R2] Read-precharge interrupted by read: precharge at once
// [R3] Write ends read burst, precharge same edge
// [R4] Controller masks data two clocks before write
// [R5] Read ends write; precharge after write gap
// [R6] Last stored word precedes interrupting read
// [R7] Write ends write; precharge after write gap
// [R8] Clock-enable fall action from prior state
// [R9] Enable low twice: hold low-power state
// [R10] Power-down exit with NOP, idle next edge
// [R11] Self-refresh exit waits exit delay
// [R12] Suspend exit: next command one edge later
// [R13] Burst-stop pattern doubles as deep power-down
// [R14] Controller avoids undefined enable/command combinations
// [R15] Bank decode only with enable high twice
// [R16] Inhibit and NOP continue current operation
// [R17] Strobe patterns decode to the command set
// [R18] Idle and row-active banks accept listed commands
// [R19] Read burst accepts read, write, stop, precharge
// [R20] Write burst accepts read, write, stop, precharge
// [R21] Bank states: idle, active, read, write
// [R22] Controller leaves busy banks alone
// [R23] Refresh and mode load only all-idle
// [R24] Timing intervals are parameterised cycle counters
`ifndef DBCS_DEFINES_SVH
`define DBCS_DEFINES_SVH

`define DBCS_CLK_MHZ       50
`define DBCS_NS_TO_CYC(ns) ((((ns) * `DBCS_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `DBCS_CLK_MHZ + 999) / 1000))
`define DBCS_T_RCD_NS      20
`define DBCS_T_RP_NS       20
`define DBCS_T_WR_NS       15
`define DBCS_T_XSR_NS      120
`define DBCS_RCD_CYC       `DBCS_NS_TO_CYC(`DBCS_T_RCD_NS)
`define DBCS_RP_CYC        `DBCS_NS_TO_CYC(`DBCS_T_RP_NS)
`define DBCS_WR_CYC        `DBCS_NS_TO_CYC(`DBCS_T_WR_NS)
`define DBCS_XSR_CYC       `DBCS_NS_TO_CYC(`DBCS_T_XSR_NS)
`define DBCS_READ_LATENCY  3
`define DBCS_MASK_RD_LAT   2
`define DBCS_BURST_LEN     4
`define DBCS_FIFO_DEPTH    4
`define DBCS_DATA_W        16
`define DBCS_ADDR_W        13
`define DBCS_COL_W         9
`define DBCS_BANK_W        2
`define DBCS_NUM_BANKS     4
`define DBCS_AP_BIT        10
`define DBCS_CNT_W         8

`endif

// >>> src/dbcs_fifo.sv
`include "dbcs_defines.svh"
`default_nettype none
module dbcs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `DBCS_FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
		$error("dbcs_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W:0]   count_ff;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_ff != (PTR_W + 1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o  = mem_ff[rd_ptr_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule // dbcs_fifo
`default_nettype wire

// >>> src/dbcs_pkg.sv
`default_nettype none
package dbcs_pkg;

	typedef enum logic [3:0] {
		DBCS_CMD_INHIBIT,
		DBCS_CMD_NOP,
		DBCS_CMD_ACTIVE,
		DBCS_CMD_REFRESH,
		DBCS_CMD_LOAD_MODE,
		DBCS_CMD_PRECHARGE,
		DBCS_CMD_READ,
		DBCS_CMD_WRITE,
		DBCS_CMD_BURST_STOP
	} dbcs_cmd_t;

	typedef enum logic [3:0] {
		DBCS_BANK_IDLE,
		DBCS_BANK_ACTIVATING,
		DBCS_BANK_ACTIVE,
		DBCS_BANK_READ,
		DBCS_BANK_WRITE,
		DBCS_BANK_READ_AP,
		DBCS_BANK_WRITE_AP,
		DBCS_BANK_WR_GAP,
		DBCS_BANK_PRECHARGING
	} dbcs_bank_state_t;

	typedef enum logic [2:0] {
		DBCS_PWR_NORMAL,
		DBCS_PWR_DOWN,
		DBCS_PWR_SELF_REFRESH,
		DBCS_PWR_SR_EXIT,
		DBCS_PWR_SUSPEND,
		DBCS_PWR_DEEP_DOWN
	} dbcs_pwr_t;

endpackage
`default_nettype wire

// >>> verif/dbcs_array_model.sv
`default_nettype none
module dbcs_array_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        stall_i,
	input  wire logic        rd_valid_i,
	input  wire logic [1:0]  rd_bank_i,
	input  wire logic [8:0]  rd_col_i,
	output logic      [15:0] rd_data_o,
	output logic             wr_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] pace_ff;
	logic       stall_ff;
	always_ff @(posedge clk_i) begin
		stall_ff <= stall_i;
		pace_ff  <= reset_i ? 2'h0 : pace_ff + 2'h1;
	end
	// Unrequested reads show the inverse word
	assign rd_data_o  = {16{!rd_valid_i}} ^ {5'h00, rd_bank_i, rd_col_i};
	// Drain stalls one cycle in four
	assign wr_ready_o = !stall_ff && pace_ff != 2'h0;
endmodule // dbcs_array_model
`default_nettype wire

// >>> verif/dbcs_core_bench.sv
`default_nettype none
module dbcs_core_bench
	import dbcs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2;
	logic        clk_i = 1'b0, reset_i = 1'b1, ck = 1'b0, dm = 1'b0, hold = 1'b0;
	logic [3:0]  cmd = 4'hf, bidle;
	logic [1:0]  ba = 2'h0, actb, rdb, wb;
	logic [12:0] ad = 13'h0000, actr, r;
	logic [15:0] wd = 16'h0000, rdat, ardat, wdat;
	logic [8:0]  rdc, wc, c, d;
	logic        roe, wrdy, actv, rdv, wv, wrr;
	dbcs_pwr_t   pm;
	int          n_mismatch = 0, check_count = 0;
	logic [26:0] wq[$];
	always #10 clk_i = ~clk_i;
	dbcs_core u_dut (.clk_i, .reset_i, .clock_enable_input_i(ck), .chip_select_n_i(cmd[3]),
		.row_strobe_n_i(cmd[2]), .column_strobe_n_i(cmd[1]), .write_strobe_n_i(cmd[0]), .bank_i(ba),
		.addr_i(ad), .data_mask_i(dm), .write_data_i(wd), .read_data_o(rdat), .read_data_oe_o(roe),
		.write_ready_o(wrdy), .arr_act_valid_o(actv), .arr_act_bank_o(actb), .arr_act_row_o(actr),
		.arr_rd_valid_o(rdv), .arr_rd_bank_o(rdb), .arr_rd_col_o(rdc), .arr_rd_data_i(ardat),
		.arr_wr_valid_o(wv), .arr_wr_ready_i(wrr), .arr_wr_bank_o(wb), .arr_wr_col_o(wc),
		.arr_wr_data_o(wdat), .power_mode_o(pm), .bank_idle_o(bidle));
	dbcs_array_model u_mem (.clk_i, .reset_i, .stall_i(hold), .rd_valid_i(rdv),
		.rd_bank_i(rdb), .rd_col_i(rdc), .rd_data_o(ardat), .wr_ready_o(wrr));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (e !== s) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic step(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a);
		@(negedge clk_i);
		cmd = p;
		ba = b;
		ad = a;
		wd = 16'($urandom);
	endtask
	task automatic nop(input int n);
		repeat (n) step(NOP, 2'h0, 13'h0000);
	endtask
	task automatic push(input logic [1:0] b, input logic [8:0] col);
		wq.push_back({b, col, wd});
	endtask
	function automatic logic [15:0] exp_rd(input logic [1:0] b, input logic [8:0] col);
		return {5'h00, b, col};
	endfunction
	task automatic burst(input logic [1:0] b, input logic [8:0] col, input int w);
		nop(w);
		for (int i = 0; i < 4; i++) begin
			chk("oe", 1, roe);
			chk("rdata", exp_rd(b, col + 9'(i)), rdat);
			nop(1);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Drained words
	always @(negedge clk_i) begin
		if (!reset_i && (wv & wrr) === 1'b1) begin
			if (wq.size() == 0) chk("wr_extra", 0, 1);
			else chk("wr_word", wq.pop_front(), {wb, wc, wdat});
		end
	end
	initial begin
		#(20 * 3000);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h89b4_f0bc));
		repeat (4) @(negedge clk_i);
		reset_i = 1'b0;
		ck = 1'b1;
		chk("idle", 4'hf, bidle);
		chk("mode", DBCS_PWR_NORMAL, pm);
		chk("wrdy", 1, wrdy);
		nop(2);
		repeat (24) begin
			step({1'b1, 3'($urandom)}, 2'($urandom), 13'($urandom));
			chk("inhibit", 0, actv);
		end
		for (int b = 0; b < 4; b++) begin
			r = 13'($urandom);
			step(ACT, 2'(b), r);
			nop(1);
			chk("act", 1, actv);
			chk("row", r, actr);
			chk("abank", b, actb);
		end
		c = 9'($urandom);
		d = 9'($urandom);
		step(RD, 2'h3, {4'h0, c});
		burst(2'h3, c, 4);
		step(RD, 2'h0, {4'h2, c});
		step(RD, 2'h1, {4'h0, d});
		nop(3);
		chk("idle0", 1, bidle[0]);
		chk("old", exp_rd(2'h0, c), rdat);
		burst(2'h1, d, 1);
		step(RD, 2'h1, {4'h2, c});
		dm = 1'b1;
		nop(2);
		dm = 1'b0;
		step(WR, 2'h3, {4'h2, d});
		push(2'h3, d);
		step(ACT, 2'h0, r);
		push(2'h3, d + 9'h001);
		chk("oe_cut", 0, roe);
		nop(1);
		push(2'h3, d + 9'h002);
		step(WR, 2'h2, {4'h2, c});
		push(2'h2, c);
		chk("idle1", 1, bidle[1]);
		nop(1);
		push(2'h2, c + 9'h001);
		step(RD, 2'h0, {4'h0, d});
		nop(2);
		chk("idle3", 1, bidle[3]);
		chk("gap2", 0, bidle[2]);
		burst(2'h0, d, 2);
		chk("idle2", 1, bidle[2]);
		hold = 1'b1;
		nop(2);
		step(WR, 2'h0, {4'h0, c});
		push(2'h0, c);
		for (int i = 1; i < 4; i++) begin
			nop(1);
			push(2'h0, c + 9'(i));
		end
		nop(1);
		chk("full", 0, wrdy);
		hold = 1'b0;
		nop(12);
		chk("drained", 0, wq.size());
		step(PRE, 2'h0, 13'h0400);
		nop(3);
		chk("allidle", 4'hf, bidle);
		ck = 1'b0;
		nop(3);
		chk("pd", DBCS_PWR_DOWN, pm);
		step(ACT, 2'h1, r);
		nop(1);
		chk("ignored", 0, actv);
		ck = 1'b1;
		step(ACT, 2'h1, r);
		chk("pdx", DBCS_PWR_NORMAL, pm);
		nop(1);
		chk("act_n1", 1, actv);
		step(PRE, 2'h1, 13'h0000);
		nop(2);
		step(4'h1, 2'h0, 13'h0000);
		ck = 1'b0;
		nop(2);
		chk("sr", DBCS_PWR_SELF_REFRESH, pm);
		ck = 1'b1;
		nop(1);
		chk("srx", DBCS_PWR_SR_EXIT, pm);
		nop(7);
		chk("srn", DBCS_PWR_NORMAL, pm);
		step(4'h6, 2'h0, 13'h0000);
		ck = 1'b0;
		nop(2);
		chk("deep", DBCS_PWR_DEEP_DOWN, pm);
		ck = 1'b1;
		nop(2);
		chk("deepx", DBCS_PWR_NORMAL, pm);
		step(ACT, 2'h0, r);
		nop(1);
		step(RD, 2'h0, {4'h0, c});
		nop(1);
		ck = 1'b0;
		nop(1);
		chk("susp", DBCS_PWR_SUSPEND, pm);
		ck = 1'b1;
		step(ACT, 2'h1, r);
		nop(1);
		chk("resume", 1, actv);
		end_of_test();
	end
endmodule // dbcs_core_bench
`default_nettype wire

// >>> verif/dbcs_core_chk.sv
`include "dbcs_defines.svh"
`default_nettype none
module dbcs_core_chk
	import dbcs_pkg::*;
#(
	parameter int XSR_CYC = `DBCS_XSR_CYC
) (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        clock_enable_input_i,
	input wire logic        chip_select_n_i,
	input wire logic        row_strobe_n_i,
	input wire logic        column_strobe_n_i,
	input wire logic        write_strobe_n_i,
	input wire logic [1:0]  bank_i,
	input wire logic [12:0] addr_i,
	input wire logic [15:0] read_data_o,
	input wire logic        read_data_oe_o,
	input wire logic        arr_act_valid_o,
	input wire logic [1:0]  arr_act_bank_o,
	input wire logic [12:0] arr_act_row_o,
	input wire logic        arr_rd_valid_o,
	input wire logic [15:0] arr_rd_data_i,
	input wire dbcs_pwr_t   power_mode_o,
	input wire logic [3:0]  bank_idle_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] c;
	logic       k;
	logic [7:0] sr_cnt_ff;
	assign c = {chip_select_n_i, row_strobe_n_i, column_strobe_n_i, write_strobe_n_i};
	assign k = clock_enable_input_i;
	// Exit wait cycles
	always_ff @(posedge clk_i) begin
		sr_cnt_ff <= (reset_i || power_mode_o != DBCS_PWR_SR_EXIT) ? 8'h00 : sr_cnt_ff + 8'h01;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	act_fwd_a:
	assert property (!$past(reset_i) && $past(k) && k && c == 4'h3 && power_mode_o == DBCS_PWR_NORMAL
		&& bank_idle_o[bank_i] |=> arr_act_valid_o && arr_act_bank_o == $past(bank_i)
		&& arr_act_row_o == $past(addr_i)) else $error("activate lost");
	pd_enter_a:
	assert property (!$past(reset_i) && $past(k) && !k && c == 4'h7 && &bank_idle_o
		&& power_mode_o == DBCS_PWR_NORMAL && !read_data_oe_o |=> power_mode_o == DBCS_PWR_DOWN)
		else $error("no power-down");
	sr_enter_a:
	assert property (!$past(reset_i) && $past(k) && !k && c == 4'h1 && &bank_idle_o
		&& power_mode_o == DBCS_PWR_NORMAL |=> power_mode_o == DBCS_PWR_SELF_REFRESH) else $error("no self refresh");
	deep_enter_a:
	assert property (!$past(reset_i) && $past(k) && !k && c == 4'h6 && &bank_idle_o
		&& power_mode_o == DBCS_PWR_NORMAL |=> power_mode_o == DBCS_PWR_DEEP_DOWN) else $error("no deep down");
	hold_low_a:
	assert property (!k && !(power_mode_o inside {DBCS_PWR_NORMAL, DBCS_PWR_SR_EXIT}) |=> $stable(power_mode_o))
		else $error("low-power state left");
	pd_exit_a:
	assert property (power_mode_o == DBCS_PWR_DOWN && k && c == 4'h7 |=> power_mode_o == DBCS_PWR_NORMAL)
		else $error("no power-down exit");
	sr_wait_a:
	assert property ($past(power_mode_o) == DBCS_PWR_SR_EXIT && power_mode_o != DBCS_PWR_SR_EXIT
		|-> sr_cnt_ff == 8'(XSR_CYC)) else $error("exit wait length");
	rd_word_a:
	assert property (arr_rd_valid_o && k && power_mode_o == DBCS_PWR_NORMAL
		|=> !read_data_oe_o || read_data_o == $past(arr_rd_data_i)) else $error("read word wrong");
endmodule // dbcs_core_chk

bind dbcs_core dbcs_core_chk #(.XSR_CYC(XSR_CYC)) u_chk (.*);
`default_nettype wire
